// ==== hdl/strap_cfg_pkg.sv ====
// constants, field layouts and state encodings for the power-up strap loader
package strap_cfg_pkg;

  // four-lane port groups in the switch fabric
  localparam int NUM_GROUPS = 4;

  // compatibility strap codes
  localparam logic [1:0] COMP_ALL_SINGLE = 2'h0;
  localparam logic [1:0] COMP_MIXED = 2'h1;
  localparam logic [1:0] COMP_NATIVE = 2'h2;
  localparam logic [1:0] COMP_RESERVED = 2'h3;

  // four-lane group masks for each grouping code
  localparam logic [3:0] FOUR_LANE_ALL_SINGLE = 4'h0;
  localparam logic [3:0] FOUR_LANE_MIXED = 4'h3;
  localparam logic [3:0] FOUR_LANE_NATIVE = 4'hf;

  // line rate strap codes
  localparam logic [1:0] RATE_1G25 = 2'h0;
  localparam logic [1:0] RATE_2G5 = 2'h1;
  localparam logic [1:0] RATE_3G125 = 2'h2;
  localparam logic [1:0] RATE_ILLEGAL = 2'h3;

  // synchronised pin vector layout
  localparam int PIN_W = 8;
  localparam int PIN_COMP_LSB = 0;
  localparam int PIN_RATE_LSB = 2;
  localparam int PIN_REFCLK = 4;
  localparam int PIN_RX = 5;
  localparam int PIN_TX = 6;
  localparam int PIN_TEST = 7;
  localparam logic [7:0] PIN_RESET_VAL = 8'h00;

  // status register byte address and lane register page (byte address bits 11:4)
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [7:0] ADDR_LANE_PAGE = 8'h01;

  // status register fields
  localparam int ST_COMP_LSB = 0;
  localparam int ST_RATE_LSB = 2;
  localparam int ST_REFCLK = 4;
  localparam int ST_RX = 5;
  localparam int ST_TX = 6;
  localparam int ST_COMP_ERR = 8;
  localparam int ST_RATE_ERR = 9;
  localparam int ST_SAMPLED = 16;

  // lane control register fields
  localparam int LC_RATE_LSB = 0;
  localparam int LC_RX_SWAP = 2;
  localparam int LC_TX_SWAP = 3;

  // one-hot capture sequencer states
  typedef enum logic [3:0] {
    ST_SYNC0 = 4'h1,
    ST_SYNC1 = 4'h2,
    ST_LOAD = 4'h4,
    ST_HOLD = 4'h8
  } cap_state_type;

endpackage

// ==== hdl/powerup_strap_config.sv ====
// power-up strap capture, decode and lane-order control with apb registers
`timescale 1ns/10ps

module powerup_strap_config
  import strap_cfg_pkg::*;
(
  input wire logic I_CORE_CLK, // core clock, 20 MHz
  input wire logic I_RST_N, // hard reset, async, active low
  input wire logic [1:0] I_COMP_MODE_STRAP, // grouping strap pins
  input wire logic [1:0] I_LINE_RATE_STRAP, // line rate strap pins, input side
  output logic [1:0] O_LINE_RATE_STRAP, // line rate strap pins, output side
  output logic O_LINE_RATE_STRAP_OE, // line rate pin driver enable
  input wire logic I_REFCLK_FREQ_STRAP, // refclk strap pin, input side
  output logic O_REFCLK_FREQ_STRAP, // refclk strap pin, output side
  output logic O_REFCLK_FREQ_STRAP_OE, // refclk pin driver enable
  input wire logic I_RX_LANE_ORDER_STRAP, // receive lane order strap
  input wire logic I_TX_LANE_ORDER_STRAP, // transmit lane order strap
  input wire logic I_TEST_MODE, // device test mode pin
  input wire logic I_PSEL, // apb select
  input wire logic I_PENABLE, // apb enable
  input wire logic I_PWRITE, // apb direction
  input wire logic [11:0] I_PADDR, // apb byte address
  input wire logic [31:0] I_PWDATA, // apb write data
  output logic [31:0] O_PRDATA, // apb read data
  output logic O_PREADY, // apb ready
  output logic O_PSLVERR, // apb error
  output logic [3:0] O_FOUR_LANE, // per-group four-lane operation
  output logic [1:0] O_LINE_RATE, // effective line rate code
  output logic O_SERDES_PLL_125, // serdes_pll set for 125 MHz reference
  output logic [3:0] O_RX_LANE_REVERSE, // per-group receive lane reversal
  output logic [3:0] O_TX_LANE_REVERSE, // per-group transmit lane reversal
  output logic O_POWERUP_SAMPLED // straps captured and held
);

  // two-stage synchroniser on every strap and test pin
  logic [PIN_W-1:0] pin_vec;
  logic [PIN_W-1:0] sync_s1_q;
  logic [PIN_W-1:0] sync_s2_q;
  assign pin_vec = {I_TEST_MODE, I_TX_LANE_ORDER_STRAP, I_RX_LANE_ORDER_STRAP, I_REFCLK_FREQ_STRAP,
                    I_LINE_RATE_STRAP, I_COMP_MODE_STRAP};
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sync_s1_q <= PIN_RESET_VAL;
      sync_s2_q <= PIN_RESET_VAL;
    end
    else
    begin
      sync_s1_q <= pin_vec;
      sync_s2_q <= sync_s1_q;
    end
  end

  // capture sequencer: async reset forces constants, so the pins are
  // latched once the synchroniser has refilled after the release
  cap_state_type state_q;
  cap_state_type state_d;
  logic [6:0] strap_q;
  logic [6:0] strap_d;
  always_comb
  begin
    state_d = state_q;
    strap_d = strap_q;
    case (state_q)
      ST_SYNC0: state_d = ST_SYNC1;
      ST_SYNC1: state_d = ST_LOAD;
      ST_LOAD:
      begin
        strap_d = sync_s2_q[6:0];
        state_d = ST_HOLD;
      end
      ST_HOLD: state_d = ST_HOLD;
      default: state_d = ST_SYNC0;
    endcase
  end
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state_q <= ST_SYNC0;
      strap_q <= 7'h00;
    end
    else
    begin
      state_q <= state_d;
      strap_q <= strap_d;
    end
  end

  // captured strap fields
  logic [1:0] comp_raw;
  logic [1:0] rate_raw;
  logic refclk_raw;
  logic rx_raw;
  logic tx_raw;
  logic held;
  assign comp_raw = strap_q[PIN_COMP_LSB +: 2];
  assign rate_raw = strap_q[PIN_RATE_LSB +: 2];
  assign refclk_raw = strap_q[PIN_REFCLK];
  assign rx_raw = strap_q[PIN_RX];
  assign tx_raw = strap_q[PIN_TX];
  assign held = (state_q == ST_HOLD);
  // decode with fallback; outputs stay at safe zero until the hold state
  logic [3:0] four_lane_d;
  logic [1:0] rate_d;
  logic pll_d;
  logic comp_err;
  logic rate_err;
  always_comb
  begin
    comp_err = held && (comp_raw == COMP_RESERVED);
    rate_err = held && (rate_raw == RATE_ILLEGAL);
    four_lane_d = FOUR_LANE_ALL_SINGLE;
    rate_d = RATE_1G25;
    pll_d = 1'b0;
    if (held)
    begin
      case (comp_raw)
        COMP_ALL_SINGLE: four_lane_d = FOUR_LANE_ALL_SINGLE;
        COMP_MIXED: four_lane_d = FOUR_LANE_MIXED;
        COMP_NATIVE: four_lane_d = FOUR_LANE_NATIVE;
        default: four_lane_d = FOUR_LANE_NATIVE;
      endcase
      rate_d = rate_err ? RATE_3G125 : rate_raw;
      pll_d = refclk_raw;
    end
  end
  // apb slave: one wait state, ready and data both registered
  logic access;
  logic done;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic lane_hit;
  logic [1:0] lane_idx;
  logic [3:0] rx_ovr_q;
  logic [3:0] tx_ovr_q;
  logic [3:0] rx_sw_q;
  logic [3:0] tx_sw_q;
  logic [3:0] rx_sel;
  logic [3:0] tx_sel;
  assign access = I_PSEL && I_PENABLE;
  assign done = access && pready_q;
  assign lane_hit = (I_PADDR[11:4] == ADDR_LANE_PAGE) && (I_PADDR[1:0] == 2'h0);
  assign lane_idx = I_PADDR[3:2];
  always_comb
  begin
    pready_d = access && !pready_q;
    pslverr_d = 1'b0;
    prdata_d = 32'h00000000;
    if (access && !pready_q)
    begin
      if (I_PADDR == ADDR_STATUS)
      begin
        if (!I_PWRITE)
        begin
          prdata_d[ST_COMP_LSB +: 2] = comp_raw;
          prdata_d[ST_RATE_LSB +: 2] = rate_raw;
          prdata_d[ST_REFCLK] = refclk_raw;
          prdata_d[ST_RX] = rx_raw;
          prdata_d[ST_TX] = tx_raw;
          prdata_d[ST_COMP_ERR] = comp_err;
          prdata_d[ST_RATE_ERR] = rate_err;
          prdata_d[ST_SAMPLED] = held;
        end
      end
      else if (lane_hit)
      begin
        if (!I_PWRITE)
        begin
          prdata_d[LC_RATE_LSB +: 2] = rate_raw;
          prdata_d[LC_RX_SWAP] = rx_sel[lane_idx];
          prdata_d[LC_TX_SWAP] = tx_sel[lane_idx];
        end
      end
      else
      begin
        pslverr_d = 1'b1; // unmapped address answers with an error
      end
    end
  end
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end
  // per-group lane order: software value wins once written
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++)
    begin : grp
      logic wr_hit;
      logic rx_ovr_d;
      logic tx_ovr_d;
      logic rx_sw_d;
      logic tx_sw_d;
      assign wr_hit = done && I_PWRITE && lane_hit && (lane_idx == 2'(g));
      assign rx_sel[g] = rx_ovr_q[g] ? rx_sw_q[g] : rx_raw;
      assign tx_sel[g] = tx_ovr_q[g] ? tx_sw_q[g] : tx_raw;
      always_comb
      begin
        rx_ovr_d = rx_ovr_q[g] || wr_hit;
        tx_ovr_d = tx_ovr_q[g] || wr_hit;
        rx_sw_d = wr_hit ? I_PWDATA[LC_RX_SWAP] : rx_sw_q[g];
        tx_sw_d = wr_hit ? I_PWDATA[LC_TX_SWAP] : tx_sw_q[g];
      end
      always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
      begin
        if (!I_RST_N)
        begin
          rx_ovr_q[g] <= 1'b0;
          tx_ovr_q[g] <= 1'b0;
          rx_sw_q[g] <= 1'b0;
          tx_sw_q[g] <= 1'b0;
        end
        else
        begin
          rx_ovr_q[g] <= rx_ovr_d;
          tx_ovr_q[g] <= tx_ovr_d;
          rx_sw_q[g] <= rx_sw_d;
          tx_sw_q[g] <= tx_sw_d;
        end
      end
    end
  endgenerate
  // effective reversal; single-lane groups never swap, a swapped group
  // dropped to single lanes could not reach a single-lane partner
  logic [3:0] rx_rev_d;
  logic [3:0] tx_rev_d;
  logic test_en;
  assign test_en = sync_s2_q[PIN_TEST];
  always_comb
  begin
    rx_rev_d = four_lane_d & rx_sel;
    tx_rev_d = four_lane_d & tx_sel;
  end

  // registered outputs
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_FOUR_LANE <= 4'h0;
      O_LINE_RATE <= 2'h0;
      O_SERDES_PLL_125 <= 1'b0;
      O_RX_LANE_REVERSE <= 4'h0;
      O_TX_LANE_REVERSE <= 4'h0;
      O_POWERUP_SAMPLED <= 1'b0;
      O_LINE_RATE_STRAP_OE <= 1'b0;
      O_REFCLK_FREQ_STRAP_OE <= 1'b0;
    end
    else
    begin
      O_FOUR_LANE <= four_lane_d;
      O_LINE_RATE <= rate_d;
      O_SERDES_PLL_125 <= pll_d;
      O_RX_LANE_REVERSE <= rx_rev_d;
      O_TX_LANE_REVERSE <= tx_rev_d;
      O_POWERUP_SAMPLED <= held;
      O_LINE_RATE_STRAP_OE <= test_en;
      O_REFCLK_FREQ_STRAP_OE <= test_en;
    end
  end
  // in test mode the pins echo the captured levels
  assign O_LINE_RATE_STRAP = strap_q[PIN_RATE_LSB +: 2];
  assign O_REFCLK_FREQ_STRAP = strap_q[PIN_REFCLK];
  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  // checks
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_lane_rd;
    access && !I_PWRITE && lane_hit && !pready_q;
  endsequence
  sequence s_lane_wr(logic [1:0] idx);
    done && I_PWRITE && lane_hit && (lane_idx == idx);
  endsequence
  a_oe_test_only: assert property (!test_en |=> !O_LINE_RATE_STRAP_OE && !O_REFCLK_FREQ_STRAP_OE)
    else $error("strap pin driver enabled outside test mode");
  a_comp_single: assert property (held && comp_raw == COMP_ALL_SINGLE |=> O_FOUR_LANE == 4'h0)
    else $error("all-single grouping left a four-lane group");
  a_comp_mixed: assert property (held && comp_raw == COMP_MIXED |=> O_FOUR_LANE == 4'h3)
    else $error("mixed grouping decoded wrongly");
  a_rate_fallback: assert property (held && rate_raw == RATE_ILLEGAL |=> O_LINE_RATE == 2'h2 && rate_err)
    else $error("illegal line rate did not fall back");
  a_rate_follow: assert property (held && rate_raw != RATE_ILLEGAL |=> O_LINE_RATE == $past(rate_raw))
    else $error("line rate output differs from strap");
  a_rate_mirror: assert property (held ##0 s_lane_rd |=> O_PREADY && O_PRDATA[1:0] == rate_raw)
    else $error("lane register does not mirror line rate strap");
  a_pll_select: assert property (held |=> O_SERDES_PLL_125 == $past(refclk_raw))
    else $error("serdes pll reference select wrong");
  a_single_noswap: assert property (!O_FOUR_LANE[0] |-> !O_RX_LANE_REVERSE[0] && !O_TX_LANE_REVERSE[0])
    else $error("single-lane group shows lane reversal");
  a_strap_order: assert property (held && !rx_ovr_q[0] && four_lane_d[0] |=> O_RX_LANE_REVERSE[0] == rx_raw)
    else $error("receive lane order not taken from strap");
  a_sw_override: assert property (held ##0 s_lane_wr(2'h0) |=> rx_ovr_q[0] ##1 O_RX_LANE_REVERSE[0]
                                  == (O_FOUR_LANE[0] && rx_sw_q[0]))
    else $error("software lane order did not override strap");
  // the release edge still samples reset low and leaves the state put, so no walk starts there
  a_capture_walk: assert property (I_RST_N && state_q == ST_SYNC0 |=> state_q == ST_SYNC1 ##1 state_q == ST_LOAD
                                   ##1 state_q == ST_HOLD)
    else $error("strap capture sequence broken");
  a_hold_stable: assert property (held |=> held && $stable(strap_q))
    else $error("captured straps changed after capture");

endmodule

// ==== dv/strap_board.sv ====
// board strap tie-offs with pin resolution for the two-way strap pins
`timescale 1ns/10ps
module strap_board
(
  input wire logic [7:0] i_tie, // board levels: tx, rx, refclk, rate[1:0], comp[1:0]
  input wire logic [1:0] i_rate_drv, // device drive on line rate pins
  input wire logic i_rate_oe, // device enable on line rate pins
  input wire logic i_ref_drv, // device drive on refclk pin
  input wire logic i_ref_oe, // device enable on refclk pin
  output logic [1:0] o_comp, // grouping pins
  output logic [1:0] o_rate, // line rate pins
  output logic o_ref, // refclk pin
  output logic o_rx, // receive lane order pin
  output logic o_tx // transmit lane order pin
);
  // device wins only while it drives, the tie-off resistor otherwise
  assign o_comp = i_tie[1:0];
  assign o_rate = i_rate_oe ? i_rate_drv : i_tie[3:2];
  assign o_ref = i_ref_oe ? i_ref_drv : i_tie[4];
  assign o_rx = i_tie[5];
  assign o_tx = i_tie[6];
endmodule

// ==== dv/powerup_strap_config_bench.sv ====
// self-checking bench for the power-up strap loader
`timescale 1ns/10ps
module powerup_strap_config_bench;
  import strap_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] tie = 8'h02;
  logic test_mode = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, rate_oe, ref_drv, ref_oe, pll125, sampled, ref_pin, rx_pin, tx_pin;
  logic [1:0] rate_drv, comp_pin, rate_pin, line_rate;
  logic [3:0] four_lane, rx_rev, tx_rev;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  powerup_strap_config u_powerup_strap_config (.I_CORE_CLK(clk), .I_RST_N(rst_n),
    .I_COMP_MODE_STRAP(comp_pin), .I_LINE_RATE_STRAP(rate_pin), .O_LINE_RATE_STRAP(rate_drv),
    .O_LINE_RATE_STRAP_OE(rate_oe), .I_REFCLK_FREQ_STRAP(ref_pin), .O_REFCLK_FREQ_STRAP(ref_drv),
    .O_REFCLK_FREQ_STRAP_OE(ref_oe), .I_RX_LANE_ORDER_STRAP(rx_pin), .I_TX_LANE_ORDER_STRAP(tx_pin),
    .I_TEST_MODE(test_mode), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_FOUR_LANE(four_lane), .O_LINE_RATE(line_rate), .O_SERDES_PLL_125(pll125),
    .O_RX_LANE_REVERSE(rx_rev), .O_TX_LANE_REVERSE(tx_rev), .O_POWERUP_SAMPLED(sampled));

  strap_board u_strap_board (.i_tie(tie), .i_rate_drv(rate_drv), .i_rate_oe(rate_oe),
    .i_ref_drv(ref_drv), .i_ref_oe(ref_oe), .o_comp(comp_pin), .o_rate(rate_pin), .o_ref(ref_pin),
    .o_rx(rx_pin), .o_tx(tx_pin));

  // 20 MHz core clock
  always #25 clk = ~clk;

  task automatic end_of_test();
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge; waits for ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // straps set up before and held through release; capture ends by edge 4
  task automatic do_reset(input logic [7:0] t);
    tie <= t;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  task automatic t_decode(input logic [1:0] c, input logic [1:0] r, input logic [2:0] s);
    logic [3:0] fl;
    fl = (c == 2'h0) ? 4'h0 : (c == 2'h1) ? 4'h3 : 4'hf;
    do_reset({1'b0, s, r, c});
    chk(four_lane, fl);
    chk(line_rate, (r == 2'h3) ? 2'h2 : r);
    chk(pll125, s[0]);
    chk(rx_rev, fl & {4{s[1]}});
    chk(tx_rev, fl & {4{s[2]}});
    chk(sampled, 1'b1);
    chk({rate_oe, ref_oe}, 2'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, {15'h0, 1'b1, 6'h0, r == 2'h3, c == 2'h3, 1'b0, s, r, c});
    apb(1'b0, 12'h01c, 32'h0);
    chk(rd & 32'h3, {30'h0, r});
  endtask

  task automatic t_hold();
    do_reset(8'h7a);
    tie <= 8'h05;
    repeat (6) @(posedge clk);
    chk({four_lane, line_rate, rx_rev, tx_rev}, 14'h3eff);
    rst_n <= 1'b0;
    // values seen at this edge predate its own updates, so only an async clear shows zeros
    @(posedge clk);
    chk({four_lane, sampled, rx_rev}, 9'h0);
  endtask

  task automatic t_override();
    do_reset(8'h29);
    chk({rx_rev, tx_rev}, 8'h30);
    apb(1'b1, 12'h010, 32'h8);
    repeat (2) @(posedge clk);
    chk({rx_rev, tx_rev}, 8'h21);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'ha);
    // swap bits on a single-lane group must not reach the lanes
    apb(1'b1, 12'h018, 32'hc);
    repeat (2) @(posedge clk);
    chk({rx_rev, tx_rev}, 8'h21);
  endtask

  task automatic t_err();
    apb(1'b0, 12'h100, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h012, 32'hc);
    chk(err, 1'b1);
  endtask

  task automatic t_test();
    do_reset(8'h1a);
    test_mode <= 1'b1;
    repeat (6) @(posedge clk);
    chk({rate_oe, ref_oe, rate_drv, ref_drv}, 5'h1d);
    test_mode <= 1'b0;
    repeat (6) @(posedge clk);
    chk({rate_oe, ref_oe}, 2'h0);
  endtask

  // main sequence: every grouping and rate code, then the special cases
  initial
  begin
    for (int i = 0; i < 16; i++)
      t_decode(2'(i), 2'(i >> 2), 3'(i + 3));
    t_hold();
    t_override();
    t_err();
    t_test();
    end_of_test();
  end
endmodule
